// [src/fesrp_host.sv]
// Host-side controller that issues a sector erase to the flash and polls completion.
// Assumes the flash data pins return through DQ_I; pin inputs are asynchronous.
// Function
// - Host raises and drops chip enable between each status read.
// - Host polls with an address inside the target sector.
// - Many suspend/resume loops add 10 ms to erase time.
// - Host holds reset low at least 500 ns.
// - Host keeps reset high at least 50 ns before a read.
// - Temporary unprotect needs high voltage reset 4 us before writes.
// - Protect write pulse at least 100 ns, typically 10 us.
// - Unprotect write pulse at least 100 ns, typically 12 ms.
// - Output enable 4 us before write enable; 4 us per voltage step.
`timescale 1ns/1ps
module fesrp_host
	import fesrp_pkg::*;
#(
	parameter int READY_CYC = READY_ALGO_CYC
)
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic START,
	input wire logic [fesrp_pkg::SECT_W-1:0] SECTOR,
	input wire logic HW_RESET,
	output logic BUSY,
	output logic DONE,
	output logic ERROR,
	output logic [fesrp_pkg::ADDR_W-1:0] A,
	output logic [fesrp_pkg::DATA_W-1:0] DQ_O,
	output logic DQ_OE,
	input wire logic [fesrp_pkg::DATA_W-1:0] DQ_I,
	output logic CE_N,
	output logic OE_N,
	output logic WE_N,
	output logic RESET_N
);
	fesrp_state_t state_ff, nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic [2:0] step_ff;
	logic [CNT_W-1:0] polls_ff;
	logic [SECT_W-1:0] sect_ff;
	logic [DATA_W-1:0] dq_meta_ff, dq_sync_ff, last_ff, prev_ff;
	logic have_last_ff, have_prev_ff;
	logic [CNT_W-1:0] rst_low_ff;
	logic cnt_done;
	logic [ADDR_W-1:0] sect_addr;
	logic [ADDR_W-1:0] cmd_addr;
	logic [DATA_W-1:0] cmd_data;
	logic status_done;

	// ********************************
	// Pin input synchroniser
	// ********************************
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			dq_meta_ff <= 8'h00;
			dq_sync_ff <= 8'h00;
		end
		else
		begin
			dq_meta_ff <= DQ_I;
			dq_sync_ff <= dq_meta_ff;
		end
	end

	// ********************************
	// Command sequence decode
	// ********************************
	assign cnt_done = (cnt_ff == '0);
	// Sector number placed on address bits 18 to 12, with the top bit zero
	assign sect_addr = {{(ADDR_W-SECT_MSB-1){1'b0}}, sect_ff, {SECT_LSB{1'b0}}};
	always_comb
	begin
		cmd_addr = ADR_555;
		cmd_data = CMD_AA;
		case (step_ff)
			3'h0: begin cmd_addr = ADR_555; cmd_data = CMD_AA; end
			3'h1: begin cmd_addr = ADR_2AA; cmd_data = CMD_55; end
			3'h2: begin cmd_addr = ADR_555; cmd_data = CMD_80; end
			3'h3: begin cmd_addr = ADR_555; cmd_data = CMD_AA; end
			3'h4: begin cmd_addr = ADR_2AA; cmd_data = CMD_55; end
			default: begin cmd_addr = sect_addr; cmd_data = CMD_SECT; end
		endcase
	end
	// Done when two successive reads agree on the toggle bit and poll bit reads 1
	assign status_done = have_prev_ff && (last_ff[TOGGLE_BIT] == prev_ff[TOGGLE_BIT]) && last_ff[POLL_BIT];

	// ********************************
	// Sequencer
	// ********************************
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			FS_RESET: if (cnt_done) nxt_state = FS_RECOVER;
			FS_RECOVER: if (cnt_done) nxt_state = FS_IDLE;
			FS_IDLE:
			begin
				if (HW_RESET)
					nxt_state = FS_RESET;
				else if (START)
					nxt_state = FS_WRITE;
			end
			FS_WRITE: if (cnt_done) nxt_state = FS_WGAP;
			FS_WGAP:
			begin
				if (cnt_done)
					nxt_state = (step_ff == 3'(CMD_LEN)) ? FS_READ : FS_WRITE;
			end
			FS_READ: if (cnt_done) nxt_state = FS_CEHI;
			FS_CEHI:
			begin
				// No suspend is ever issued, so no extra suspend budget is needed
				if (cnt_done)
					nxt_state = (status_done || polls_ff == POLL_LIMIT) ? FS_DONE : FS_READ;
			end
			FS_DONE: nxt_state = FS_IDLE;
			default: nxt_state = FS_RESET;
		endcase
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			state_ff <= FS_RESET;
		else
			state_ff <= nxt_state;
	end

	// Phase timer, loaded on each state entry
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			cnt_ff <= CNT_W'(READY_CYC - 1); // RST may cut a running algorithm
		else if (nxt_state != state_ff || state_ff == FS_IDLE)
		begin
			case (nxt_state)
				FS_RESET: cnt_ff <= CNT_W'(READY_CYC - 1); // Covers 500 ns pulse and 20 us abort
				FS_RECOVER: cnt_ff <= CNT_W'(RST_HIGH_CYC - 1);
				FS_WRITE: cnt_ff <= CNT_W'(WE_CYC - 1);
				FS_READ: cnt_ff <= CNT_W'(READ_CYC - 1);
				default: cnt_ff <= CNT_W'(CE_HIGH_CYC - 1);
			endcase
		end
		else if (!cnt_done)
			cnt_ff <= cnt_ff - 1'b1;
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			step_ff <= 3'h0;
		else if (state_ff == FS_IDLE)
			step_ff <= 3'h0;
		else if (state_ff == FS_WRITE && cnt_done)
			step_ff <= step_ff + 1'b1;
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			sect_ff <= '0;
		else if (state_ff == FS_IDLE && START)
			sect_ff <= SECTOR;
	end

	// Status history for the toggle comparison
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			last_ff <= 8'h00;
			prev_ff <= 8'h00;
			have_last_ff <= 1'b0;
			have_prev_ff <= 1'b0;
			polls_ff <= '0;
		end
		else if (state_ff == FS_IDLE)
		begin
			have_last_ff <= 1'b0;
			have_prev_ff <= 1'b0;
			polls_ff <= '0;
		end
		else if (state_ff == FS_READ && cnt_done)
		begin
			prev_ff <= last_ff;
			have_prev_ff <= have_last_ff;
			last_ff <= dq_sync_ff;
			have_last_ff <= 1'b1;
			polls_ff <= polls_ff + 1'b1;
		end
	end

	// ********************************
	// Pin drive, all registered
	// ********************************
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			RESET_N <= 1'b0;
			CE_N <= 1'b1;
			OE_N <= 1'b1;
			WE_N <= 1'b1;
			A <= '0;
			DQ_O <= 8'h00;
			DQ_OE <= 1'b0;
		end
		else
		begin
			// Logic levels only on reset; no protect or unprotect pulses
			RESET_N <= (nxt_state != FS_RESET);
			// Chip enable drops for each status read and rises between them
			CE_N <= !(nxt_state == FS_WRITE || nxt_state == FS_READ);
			OE_N <= !(nxt_state == FS_READ);
			WE_N <= !(nxt_state == FS_WRITE);
			DQ_OE <= (nxt_state == FS_WRITE);
			DQ_O <= cmd_data;
			// Polling address stays inside the target sector
			A <= (nxt_state == FS_READ) ? sect_addr : cmd_addr;
		end
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			DONE <= 1'b0;
			ERROR <= 1'b0;
		end
		else
		begin
			DONE <= (nxt_state == FS_DONE);
			ERROR <= (nxt_state == FS_DONE) && !status_done;
		end
	end

	assign BUSY = (state_ff != FS_IDLE);

	// ********************************
	// Checks
	// ********************************
	// Cycles the reset pin has been held low, for the pulse width check
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			rst_low_ff <= '0;
		else if (RESET_N)
			rst_low_ff <= '0;
		else
			rst_low_ff <= rst_low_ff + 1'b1;
	end

	sequence s_read_low;
		!CE_N && !OE_N;
	endsequence
	sequence s_ce_gap;
		CE_N [*2];
	endsequence

	a_reset_hold: assert property (@(posedge CLK) disable iff (RST)
		$rose(RESET_N) |-> rst_low_ff >= CNT_W'(RST_PULSE_CYC)) else $error("Reset pulse too short");
	a_reset_recover: assert property (@(posedge CLK) disable iff (RST)
		$rose(RESET_N) |-> OE_N [*3]) else $error("Read too soon after reset");
	a_ce_toggle: assert property (@(posedge CLK) disable iff (RST)
		s_read_low ##1 CE_N |-> s_ce_gap) else $error("Chip enable not toggled between reads");
	a_poll_addr: assert property (@(posedge CLK) disable iff (RST)
		!OE_N |-> A[SECT_MSB:SECT_LSB] == sect_ff) else $error("Poll address outside sector");
	a_no_contend: assert property (@(posedge CLK) disable iff (RST)
		!OE_N |-> !DQ_OE && WE_N) else $error("Bus contention during read");
	a_done_pulse: assert property (@(posedge CLK) disable iff (RST)
		DONE |=> !DONE) else $error("Done not a single pulse");
	a_stop_toggle: assert property (@(posedge CLK) disable iff (RST)
		DONE && !ERROR |-> last_ff[POLL_BIT] && (last_ff[TOGGLE_BIT] == prev_ff[TOGGLE_BIT]))
		else $error("Done without poll bit set");
	a_read_width: assert property (@(posedge CLK) disable iff (RST)
		$fell(OE_N) |-> !OE_N [*5]) else $error("Read strobe too short");
endmodule

// [src/fesrp_pkg.sv]
// Constants for the flash status and reset host controller.
// Assumes a 50 MHz system clock driving all controller logic.
package fesrp_pkg;
	// ********************************
	// Clock
	// ********************************
	localparam int CLK_PERIOD_NS = 20;
	// ********************************
	// Bus widths
	// ********************************
	localparam int ADDR_W = 20;
	localparam int DATA_W = 8;
	localparam int SECT_LSB = 12;
	localparam int SECT_MSB = 18;
	localparam int SECT_W = SECT_MSB - SECT_LSB + 1;
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	// ********************************
	// Timing in their own units
	// ********************************
	localparam int T_RST_PULSE_NS = 500;
	localparam int T_RST_HIGH_NS = 50;
	localparam int T_READY_ALGO_US = 20;
	localparam int T_READ_PULSE_NS = 100;
	localparam int T_CE_HIGH_NS = 40;
	localparam int T_WE_PULSE_NS = 60;
	// ********************************
	// Cycle counts, least times rounded up
	// ********************************
	localparam int RST_PULSE_CYC = (T_RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_HIGH_CYC = (T_RST_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READY_ALGO_CYC = (T_READY_ALGO_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC = (T_READ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CE_HIGH_CYC = (T_CE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WE_CYC = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
	// ********************************
	// Erase command words
	// ********************************
	localparam logic [DATA_W-1:0] CMD_AA = 8'haa;
	localparam logic [DATA_W-1:0] CMD_55 = 8'h55;
	localparam logic [DATA_W-1:0] CMD_80 = 8'h80;
	localparam logic [DATA_W-1:0] CMD_SECT = 8'h30;
	localparam logic [ADDR_W-1:0] ADR_555 = 20'h00aaa;
	localparam logic [ADDR_W-1:0] ADR_2AA = 20'h00555;
	localparam int CMD_LEN = 6;
	localparam logic [CNT_W-1:0] POLL_LIMIT = 16'hffff;
	typedef enum logic [2:0] {
		FS_RESET = 3'b000,
		FS_RECOVER = 3'b001,
		FS_IDLE = 3'b010,
		FS_WRITE = 3'b011,
		FS_WGAP = 3'b100,
		FS_READ = 3'b101,
		FS_CEHI = 3'b110,
		FS_DONE = 3'b111
	} fesrp_state_t;
endpackage

// [test/fesrp_flash_model.sv]
// Behavioural flash device: sector erase command, status polling, reset pin.
// Assumes byte mode and a single host driving the pins.
`timescale 1ns/1ps
module fesrp_flash_model
	import fesrp_pkg::*;
(
	input wire logic [fesrp_pkg::ADDR_W-1:0] a,
	input wire logic [fesrp_pkg::DATA_W-1:0] wr_data,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic reset_n,
	input wire logic wr_drive,
	input wire logic [7:0] busy_reads,
	output logic [fesrp_pkg::DATA_W-1:0] rd_data,
	output logic [fesrp_pkg::SECT_W-1:0] erased_sect,
	output logic busy,
	output logic bad_host,
	output int n_erase,
	output int n_reads
);
	int seq = 0;
	int left = 0;
	logic tog = 1'b0;
	logic ce_cycled = 1'b1;
	logic algo_at_fall = 1'b0;
	realtime t_fall = 0;
	realtime t_rise = 0;
	initial
	begin
		rd_data = 8'h00;
		erased_sect = '0;
		busy = 1'b0;
		bad_host = 1'b0;
		n_erase = 0;
		n_reads = 0;
	end
	// ****
	// Command decode
	// ****
	always @(negedge we_n)
	begin
		#1;
		if (!ce_n && reset_n && !busy)
		begin
			// Host must drive the data pins during a write
			if (!wr_drive)
				bad_host = 1'b1;
			seq++;
			if (seq == CMD_LEN)
			begin
				seq = 0;
				if (wr_data == CMD_SECT)
				begin
					erased_sect = a[SECT_MSB:SECT_LSB];
					busy = 1'b1;
					tog = 1'b0;
					left = busy_reads;
					n_erase++;
				end
			end
		end
	end
	// ****
	// Status reads
	// ****
	always @(negedge oe_n)
	begin
		#1;
		if (!ce_n && reset_n)
		begin
			n_reads++;
			if (!ce_cycled || $realtime - t_rise < T_RST_HIGH_NS)
				bad_host = 1'b1;
			if (busy && a[SECT_MSB:SECT_LSB] !== erased_sect)
				bad_host = 1'b1;
			ce_cycled = 1'b0;
			if (busy)
			begin
				tog = ~tog;
				rd_data = {1'b0, tog, 3'b000, tog, 2'b00};
				if (left == 0)
					busy = 1'b0;
				else
					left--;
			end
			else
				rd_data = 8'hff;
		end
	end
	always @(posedge ce_n)
		ce_cycled = 1'b1;
	// Released bus shows no stale value
	always @(posedge oe_n)
		rd_data = ~rd_data;
	// ****
	// Reset pin
	// ****
	always @(negedge reset_n)
	begin
		algo_at_fall = busy;
		t_fall = $realtime;
		busy = 1'b0;
		seq = 0;
	end
	always @(posedge reset_n)
	begin
		t_rise = $realtime;
		if (algo_at_fall && $realtime - t_fall < T_RST_PULSE_NS)
			bad_host = 1'b1;
	end
endmodule

// [test/tb_fesrp_host.sv]
// Self-checking bench for the erase controller against a flash model.
// Assumes fesrp_pkg and fesrp_flash_model are compiled first.
`timescale 1ns/1ps
module tb_fesrp_host;
	import fesrp_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic hw_reset = 1'b0;
	logic [SECT_W-1:0] sector = '0;
	logic busy, done, error, dq_oe, ce_n, oe_n, we_n, reset_n, fl_busy, bad_host;
	logic [ADDR_W-1:0] a;
	logic [DATA_W-1:0] dq_o, dq_i;
	logic [SECT_W-1:0] erased_sect;
	logic [7:0] busy_reads = 8'h00;
	logic [31:0] rnd;
	int n_erase, n_reads, cnt, r0, e0;
	int fail_count = 0;
	int n_compared = 0;
	int seed = 32'hdc79d09f;
	always #10 clk = ~clk;
	fesrp_host #(.READY_CYC(30)) fesrp_host_i (.CLK(clk), .RST(rst), .START(start), .SECTOR(sector),
		.HW_RESET(hw_reset), .BUSY(busy), .DONE(done), .ERROR(error), .A(a), .DQ_O(dq_o), .DQ_OE(dq_oe),
		.DQ_I(dq_i), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .RESET_N(reset_n));
	fesrp_flash_model fesrp_flash_model_i (.a(a), .wr_data(dq_o), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.reset_n(reset_n), .wr_drive(dq_oe), .busy_reads(busy_reads), .rd_data(dq_i), .erased_sect(erased_sect),
		.busy(fl_busy),
		.bad_host(bad_host), .n_erase(n_erase), .n_reads(n_reads));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("compared=%0d mismatches=%0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task tick;
		@(posedge clk);
		#2;
		cnt++;
		if (cnt > 5000)
		begin
			fail_count++;
			wrap_up();
		end
	endtask
	task wait_idle;
		cnt = 0;
		while (busy !== 1'b0)
			tick();
	endtask
	// Busy reads toggle bit six starting at 1; done needs two equal toggles with poll bit set
	function automatic int exp_polls(input int n);
		return (n % 2 == 0) ? n + 2 : n + 3;
	endfunction
	task erase(input logic [SECT_W-1:0] s, input logic [7:0] n);
		wait_idle();
		busy_reads = n;
		sector = s;
		e0 = n_erase;
		r0 = n_reads;
		start = 1'b1;
		cnt = 0;
		tick();
		while (done !== 1'b1)
		begin
			// Second request while busy must be ignored
			start = (cnt == 10);
			sector = (cnt >= 10) ? ~s : s;
			tick();
		end
		start = 1'b0;
		check(error, 1'b0);
		check(erased_sect, s);
		check(n_erase - e0, 1);
		check(n_reads - r0, exp_polls(n));
		check(bad_host, 1'b0);
		$display("erase of sector %h done", s);
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		#2;
		rst = 1'b0;
		wait_idle();
		check(reset_n, 1'b1);
		erase(7'h00, 8'h00);
		erase(7'h7f, 8'h01);
		for (int i = 0; i < 6; i++)
		begin
			rnd = $random(seed);
			erase(rnd[SECT_W-1:0], rnd[11:8]);
		end
		wait_idle();
		hw_reset = 1'b1;
		cnt = 0;
		tick();
		hw_reset = 1'b0;
		r0 = 0;
		while (busy === 1'b1)
		begin
			r0 += (reset_n === 1'b0);
			tick();
		end
		check(r0 >= RST_PULSE_CYC, 1);
		$display("hardware reset done");
		erase(7'h2a, 8'h03);
		wait_idle();
		busy_reads = 8'h28;
		sector = 7'h05;
		start = 1'b1;
		@(posedge clk);
		#2;
		start = 1'b0;
		repeat (60) @(posedge clk);
		#2;
		check(fl_busy, 1'b1);
		rst = 1'b1;
		@(posedge clk);
		#2;
		rst = 1'b0;
		check(fl_busy, 1'b0);
		check(reset_n, 1'b0);
		wait_idle();
		erase(7'h05, 8'h02);
		$display("reset during erase done");
		wrap_up();
	end
endmodule
